// File: design/gpc_pkg.sv
// Shared constants and carrier types for the general-purpose pin controller.
// Assumes one pad group of 32 pins per controller instance.
package gpc_pkg;

    localparam int          PINS          = 32;
    localparam int          SAMPLE_GROUPS = 4;
    localparam logic [4:0]  GROUP_ID      = 5'h00;
    localparam logic [11:0] GROUP_STRIDE  = 12'h080;

    // Register offsets inside one group's window.
    localparam logic [6:0] OFF_DIR      = 7'h00;
    localparam logic [6:0] OFF_DIR_CLR  = 7'h04;
    localparam logic [6:0] OFF_DIR_SET  = 7'h08;
    localparam logic [6:0] OFF_DIR_FLIP = 7'h0c;
    localparam logic [6:0] OFF_OUT      = 7'h10;
    localparam logic [6:0] OFF_OUT_CLR  = 7'h14;
    localparam logic [6:0] OFF_OUT_SET  = 7'h18;
    localparam logic [6:0] OFF_OUT_FLIP = 7'h1c;
    localparam logic [6:0] OFF_IN       = 7'h20;
    localparam logic [6:0] OFF_CTRL     = 7'h24;
    localparam logic [6:0] OFF_FSEL     = 7'h30;
    localparam logic [6:0] OFF_FSEL_END = 7'h3c;
    localparam logic [6:0] OFF_PCFG     = 7'h40;
    localparam logic [6:0] OFF_PCFG_END = 7'h5c;

    // Field positions.
    localparam int BIT_ROUTE_ON = 0;
    localparam int BIT_SENSE_ON = 1;
    localparam int BIT_PULL_ON  = 2;
    localparam int LSB_EVEN_FN  = 0;
    localparam int LSB_ODD_FN   = 4;

    // Reset values.
    localparam logic [31:0] DIR_RST      = 32'h0000_0000;
    localparam logic [3:0]  CTRL_RST     = 4'h0;
    localparam logic [31:0] DBG_PIN_MASK = 32'h0000_0000;

    localparam logic [3:0] ANALOG_FUNC = 4'h1;

    // On-demand input reads clock the synchronisers for this many cycles.
    localparam logic [1:0] SYNC_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_CLR,
        OP_SET,
        OP_FLIP
    } gpc_op_t;

    typedef enum {
        PB_IDLE,
        PB_SYNC,
        PB_ANSWER
    } gpc_pb_state_t;

    typedef struct packed {
        logic        pull_on;
        logic        sense_buffer_on;
        logic        periph_route_on;
    } gpc_cfg_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } gpc_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } gpc_rsp_t;

    typedef struct packed {
        logic [31:0] level;
        logic [31:0] oe_n;
        logic [31:0] sense_on;
        logic [31:0] pull_en;
        logic [31:0] pull_up;
    } gpc_pad_t;

    typedef struct packed {
        logic [31:0] level;
        logic [31:0] drive;
    } gpc_pf_t;

    typedef struct packed {
        logic [31:0]        dir;
        logic [31:0]        out;
        logic [3:0]         ctrl;
        gpc_cfg_t [31:0]    cfg;
        logic [15:0][7:0]   fsel;
        gpc_pb_state_t      pb_state;
        logic [1:0]         pb_cnt;
        logic [6:0]         pb_off;
        gpc_rsp_t           lrsp;
        gpc_rsp_t           prsp;
        gpc_pad_t           pad;
        logic [31:0]        pf_in;
    } gpc_state_t;

endpackage : gpc_pkg

// File: design/gpc_sync.sv
// Per-pin two-stage input synchroniser with a per-pin sampling enable.
// Assumes the enable is synchronous to the clock; disabled stages hold.
`timescale 1ns/1ps
module gpc_sync
    import gpc_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic [PINS-1:0]   EN,
    input  wire logic [PINS-1:0]   D,
    output logic      [PINS-1:0]   Q
);

    typedef struct packed {
        logic [PINS-1:0] meta;
        logic [PINS-1:0] sync;
    } gpc_sync_t;

    gpc_sync_t s_q;
    gpc_sync_t s_d;

    // The first stage feeds only the second stage, never any other logic.
    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < PINS; i++)
        begin
            if (EN[i])
            begin
                s_d.meta[i] = D[i];
                s_d.sync[i] = s_q.meta[i];
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign Q = s_q.sync;

endmodule : gpc_sync

// File: design/gpc_top.sv
// General-purpose pin controller for one group of 32 pads, with a local port and a peripheral port.
// Assumes all inputs except the asynchronous RST are synchronous to REF_CLK and that the peripheral requester holds its
// request until the acknowledge pulse.
`timescale 1ns/1ps
// Overview of operation
// - Reset leaves every pad input-direction with sense buffer, driver and pull off.
// - Reset pad state is asynchronous, so it holds without a clock; debug pins differ.
// - Logic runs whenever its clock runs; no low-power freeze exists.
// - Local port wins collisions; peripheral access then waits one cycle.
// - Debug halt does not freeze any state.
// - Write guard blocks writes to all registers except from the debugger.
// - Analog function selection disables digital input, output and pull.
// - Local port answers every access next cycle, with 8/16/32-bit byte enables.
// - Local port reads/writes/sets/clears/flips direction and level; reads input.
// - Group register set sits at base plus group times 0x80.
// - Direction bit 1 means output, 0 means input.
// - Output pin drives high for level bit 1, low for 0.
// - Inputs are resynchronised; pins with sense buffer off are not sampled.
// - Sampled level is readable in input or output direction.
// - Peripheral routing replaces controller drive and sensing on the pad.
// - Direction set/clear aliases change only pins written 1.
// - Level set/clear/flip aliases change only bits written 1.
// - On-demand sampling clocks synchronisers only on a read; read waits two cycles.
// - Each continuous-sampling bit keeps eight pins' synchronisers clocked while their sense buffers are on.
// - Pin configuration byte lives at first configuration offset plus pin index.
// - Function selection byte per pin pair at first selection offset plus index/2.
// - Enabled pull follows level bit: up for 1, down for 0.
// - Output direction disables the pull.
module gpc_top
    import gpc_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire gpc_req_t          L_REQ,
    output gpc_rsp_t               L_RSP,
    input  wire gpc_req_t          P_REQ,
    input  wire logic              P_DEBUG,
    output gpc_rsp_t               P_RSP,
    input  wire logic              WRITE_GUARD_ON,
    input  wire logic [PINS-1:0]   PAD_IN,
    output gpc_pad_t               PAD,
    input  wire gpc_pf_t           PF,
    output logic      [PINS-1:0]   PF_IN
);

    gpc_state_t      s_q;
    gpc_state_t      s_d;
    logic [PINS-1:0] sync_en;
    logic [PINS-1:0] sync_q;
    logic            pb_demand;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] alias_op(input logic [31:0] old, input logic [31:0] w,
                                             input logic [3:0] be, input gpc_op_t op);
        logic [31:0] m;
        m = lane_mask(be);
        unique case (op)
            OP_WRITE: return (old & ~m) | (w & m);
            OP_CLR:   return old & ~(w & m);
            OP_SET:   return old | (w & m);
            OP_FLIP:  return old ^ (w & m);
        endcase
    endfunction : alias_op

    function automatic logic in_group(input logic [11:0] addr);
        return addr[11:7] == GROUP_ID;
    endfunction : in_group

    function automatic logic [3:0] pin_fsel(input logic [15:0][7:0] fsel, input int pin);
        logic [7:0] b;
        b = fsel[pin / 2];
        if (pin % 2 == 0)
            return b[LSB_EVEN_FN +: 4];
        else
            return b[LSB_ODD_FN +: 4];
    endfunction : pin_fsel

    function automatic logic [31:0] read_reg(input gpc_state_t s, input logic [6:0] off,
                                             input logic [31:0] in_val);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (off == OFF_DIR || off == OFF_DIR_CLR || off == OFF_DIR_SET || off == OFF_DIR_FLIP)
            r = s.dir;
        else if (off == OFF_OUT || off == OFF_OUT_CLR || off == OFF_OUT_SET || off == OFF_OUT_FLIP)
            r = s.out;
        else if (off == OFF_IN)
            r = in_val;
        else if (off == OFF_CTRL)
            r = {28'h000_0000, s.ctrl};
        else if (off >= OFF_FSEL && off <= OFF_FSEL_END)
        begin
            for (int b = 0; b < 4; b++)
                r[8*b +: 8] = s.fsel[4 * int'(off[3:2]) + b];
        end
        else if (off >= OFF_PCFG && off <= OFF_PCFG_END)
        begin
            for (int b = 0; b < 4; b++)
                r[8*b +: 8] = {5'h00, s.cfg[4 * int'(off[4:2]) + b]};
        end
        return r;
    endfunction : read_reg

    function automatic logic known_off(input logic [6:0] off, input logic local_port);
        if (off[1:0] != 2'h0)
            return 1'b0;
        if (local_port)
            return off <= OFF_IN;
        return off <= OFF_CTRL || (off >= OFF_FSEL && off <= OFF_PCFG_END);
    endfunction : known_off

    function automatic gpc_state_t write_reg(input gpc_state_t s, input gpc_req_t r);
        gpc_state_t n;
        logic [6:0] off;
        n = s;
        off = r.addr[6:0];
        unique case (off)
            OFF_DIR:      n.dir = alias_op(s.dir, r.wdata, r.be, OP_WRITE);
            OFF_DIR_CLR:  n.dir = alias_op(s.dir, r.wdata, r.be, OP_CLR);
            OFF_DIR_SET:  n.dir = alias_op(s.dir, r.wdata, r.be, OP_SET);
            OFF_DIR_FLIP: n.dir = alias_op(s.dir, r.wdata, r.be, OP_FLIP);
            OFF_OUT:      n.out = alias_op(s.out, r.wdata, r.be, OP_WRITE);
            OFF_OUT_CLR:  n.out = alias_op(s.out, r.wdata, r.be, OP_CLR);
            OFF_OUT_SET:  n.out = alias_op(s.out, r.wdata, r.be, OP_SET);
            OFF_OUT_FLIP: n.out = alias_op(s.out, r.wdata, r.be, OP_FLIP);
            OFF_CTRL:
            begin
                if (r.be[0])
                    n.ctrl = r.wdata[3:0];
            end
            default:
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (r.be[b] && off >= OFF_FSEL && off <= OFF_FSEL_END)
                        n.fsel[4 * int'(off[3:2]) + b] = r.wdata[8*b +: 8];
                    if (r.be[b] && off >= OFF_PCFG && off <= OFF_PCFG_END)
                        n.cfg[4 * int'(off[4:2]) + b] = r.wdata[8*b +: 3];
                end
            end
        endcase
        return n;
    endfunction : write_reg

    // Sampling is on when the sense buffer is on and either the pin's eight-pin group samples
    // continuously or an on-demand read is in progress; this saves the toggling power otherwise.
    // An on-demand read already clocks the synchronisers on the edge that takes it, so the answer
    // comes two cycles later than any other peripheral read.
    always_comb
    begin
        pb_demand = s_q.pb_state == PB_IDLE && P_REQ.req && !L_REQ.req && !P_REQ.we &&
                    in_group(P_REQ.addr) && P_REQ.addr[6:0] == OFF_IN;
        for (int i = 0; i < PINS; i++)
        begin
            sync_en[i] = s_q.pad.sense_on[i] &&
                         (s_q.ctrl[i / 8] || pb_demand || s_q.pb_state == PB_SYNC);
        end
    end

    gpc_sync u_sync (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .EN      (sync_en),
        .D       (PAD_IN),
        .Q       (sync_q)
    );

    always_comb
    begin
        logic       l_ok;
        logic       p_ok;
        logic       p_take;
        logic [3:0] fn;
        logic       analog;
        l_ok   = 1'b0;
        p_ok   = 1'b0;
        p_take = 1'b0;
        fn     = 4'h0;
        analog = 1'b0;
        s_d = s_q;
        s_d.lrsp.ack = 1'b0;
        s_d.lrsp.err = 1'b0;
        s_d.prsp.ack = 1'b0;
        s_d.prsp.err = 1'b0;

        // The local port has no wait states, so it is served in the cycle it asks.
        if (L_REQ.req)
        begin
            l_ok = in_group(L_REQ.addr) && known_off(L_REQ.addr[6:0], 1'b1);
            s_d.lrsp.ack   = 1'b1;
            s_d.lrsp.rdata = l_ok ? read_reg(s_q, L_REQ.addr[6:0], sync_q) : 32'h0000_0000;
            if (L_REQ.we && l_ok && !WRITE_GUARD_ON)
                s_d = write_reg(s_d, L_REQ);
            s_d.lrsp.err = !l_ok || (L_REQ.we && WRITE_GUARD_ON);
        end

        unique case (s_q.pb_state)
            PB_IDLE:
            begin
                p_take = P_REQ.req && !L_REQ.req;
                if (p_take)
                begin
                    p_ok = in_group(P_REQ.addr) && known_off(P_REQ.addr[6:0], 1'b0);
                    s_d.pb_off = P_REQ.addr[6:0];
                    if (P_REQ.we || !p_ok || P_REQ.addr[6:0] != OFF_IN || s_q.ctrl == 4'hf)
                    begin
                        s_d.prsp.ack   = 1'b1;
                        s_d.prsp.rdata = p_ok && !P_REQ.we ?
                                         read_reg(s_q, P_REQ.addr[6:0], sync_q) : 32'h0000_0000;
                        s_d.prsp.err   = !p_ok || (P_REQ.we && WRITE_GUARD_ON && !P_DEBUG);
                        if (P_REQ.we && p_ok && (!WRITE_GUARD_ON || P_DEBUG))
                            s_d = write_reg(s_d, P_REQ);
                    end
                    else
                    begin
                        s_d.pb_state = PB_SYNC;
                        s_d.pb_cnt   = 2'h1;
                    end
                end
            end
            PB_SYNC:
            begin
                s_d.pb_cnt = s_q.pb_cnt + 2'h1;
                if (s_q.pb_cnt + 2'h1 == SYNC_CYCLES)
                    s_d.pb_state = PB_ANSWER;
            end
            PB_ANSWER:
            begin
                s_d.prsp.ack   = 1'b1;
                s_d.prsp.rdata = read_reg(s_q, s_q.pb_off, sync_q);
                s_d.pb_state   = PB_IDLE;
            end
        endcase

        // Pad controls are registered from the newly written configuration, so each pad
        // follows a register write one cycle after the access.
        for (int i = 0; i < PINS; i++)
        begin
            fn     = pin_fsel(s_d.fsel, i);
            analog = s_d.cfg[i].periph_route_on && fn == ANALOG_FUNC;
            if (analog)
            begin
                s_d.pad.oe_n[i]     = 1'b1;
                s_d.pad.level[i]    = 1'b0;
                s_d.pad.sense_on[i] = 1'b0;
                s_d.pad.pull_en[i]  = 1'b0;
                s_d.pad.pull_up[i]  = 1'b0;
            end
            else if (s_d.cfg[i].periph_route_on)
            begin
                s_d.pad.oe_n[i]     = ~PF.drive[i];
                s_d.pad.level[i]    = PF.level[i];
                s_d.pad.sense_on[i] = s_d.cfg[i].sense_buffer_on;
                s_d.pad.pull_en[i]  = s_d.cfg[i].pull_on && !PF.drive[i];
                s_d.pad.pull_up[i]  = s_d.out[i];
            end
            else
            begin
                s_d.pad.oe_n[i]     = ~s_d.dir[i];
                s_d.pad.level[i]    = s_d.out[i];
                s_d.pad.sense_on[i] = s_d.cfg[i].sense_buffer_on;
                s_d.pad.pull_en[i]  = s_d.cfg[i].pull_on && !s_d.dir[i];
                s_d.pad.pull_up[i]  = s_d.out[i];
            end
            s_d.pf_in[i] = s_d.cfg[i].periph_route_on && !analog && PAD_IN[i];
        end
    end

    // Reset is asynchronous so the pads sit in the safe state before any clock edge.
    // Nothing here is gated by sleep or debug halt: state only moves with REF_CLK.
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q          <= '0;
            s_q.dir      <= DIR_RST;
            s_q.out      <= DBG_PIN_MASK;
            s_q.ctrl     <= CTRL_RST;
            s_q.pb_state <= PB_IDLE;
            s_q.pad.oe_n <= 32'hffff_ffff;
            s_q.pad.sense_on <= DBG_PIN_MASK;
            s_q.pad.pull_en  <= DBG_PIN_MASK;
            s_q.pad.pull_up  <= DBG_PIN_MASK;
            for (int i = 0; i < PINS; i++)
            begin
                s_q.cfg[i].sense_buffer_on <= DBG_PIN_MASK[i];
                s_q.cfg[i].pull_on         <= DBG_PIN_MASK[i];
            end
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign L_RSP = s_q.lrsp;
    assign P_RSP = s_q.prsp;
    assign PAD   = s_q.pad;
    assign PF_IN = s_q.pf_in;

endmodule : gpc_top

// File: verification/gpc_checker.sv
// Port-level checks for the pin controller.
// Assumes one clock domain; bound onto every gpc_top instance.
`timescale 1ns/1ps
module gpc_checker
    import gpc_pkg::*;
(
    input  wire logic            REF_CLK,
    input  wire logic            RST,
    input  wire gpc_req_t        L_REQ,
    input  wire gpc_rsp_t        L_RSP,
    input  wire gpc_req_t        P_REQ,
    input  wire logic            P_DEBUG,
    input  wire gpc_rsp_t        P_RSP,
    input  wire logic            WRITE_GUARD_ON,
    input  wire logic [PINS-1:0] PAD_IN,
    input  wire gpc_pad_t        PAD,
    input  wire gpc_pf_t         PF,
    input  wire logic [PINS-1:0] PF_IN
);
    default clocking dflt_cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence p_start;
        $rose(P_REQ.req) && !L_REQ.req;
    endsequence

    sequence in_read;
        !P_REQ.we && P_REQ.addr[6:0] == OFF_IN;
    endsequence

    loc_ack_a: assert property (L_REQ.req |=> L_RSP.ack)
        else $error("local access not answered next cycle");
    loc_idle_a: assert property (!L_REQ.req |=> !L_RSP.ack)
        else $error("local answer without request");
    loc_hold_a: assert property (!L_RSP.ack |-> $stable(L_RSP.rdata))
        else $error("local read data moved without answer");
    loc_map_a: assert property (L_REQ.req && (L_REQ.addr[11:7] != GROUP_ID || L_REQ.addr[6:0] > OFF_IN)
        |=> L_RSP.err && L_RSP.rdata == 32'h0)
        else $error("unmapped local access not refused");
    guard_err_a: assert property (L_REQ.req && L_REQ.we && WRITE_GUARD_ON |=> L_RSP.err)
        else $error("guarded local write not refused");
    p_wait_a: assert property ($rose(P_REQ.req) && L_REQ.req |=> !P_RSP.ack)
        else $error("peripheral access beat the local port");
    p_sync_a: assert property (p_start ##0 in_read |=> ##[0:2] P_RSP.ack)
        else $error("input read answer out of window");
    pull_out_a: assert property ((PAD.oe_n | ~PAD.pull_en) == 32'hffff_ffff)
        else $error("pull left on a driven pad");
    pf_src_a: assert property ((PF_IN & ~$past(PAD_IN)) == 32'h0)
        else $error("peripheral input not from the pad");
    pad_rst_a: assert property (disable iff (1'b0) RST |-> PAD.oe_n == 32'hffff_ffff
        && PAD.sense_on == DBG_PIN_MASK && PAD.pull_en == DBG_PIN_MASK)
        else $error("pads not parked during reset");
endmodule : gpc_checker

bind gpc_top gpc_checker chk_u (.REF_CLK(REF_CLK), .RST(RST), .L_REQ(L_REQ), .L_RSP(L_RSP),
    .P_REQ(P_REQ), .P_DEBUG(P_DEBUG), .P_RSP(P_RSP), .WRITE_GUARD_ON(WRITE_GUARD_ON),
    .PAD_IN(PAD_IN), .PAD(PAD), .PF(PF), .PF_IN(PF_IN));

// File: verification/gpc_pad_model.sv
// Behavioural pads: resolves controller drive, outside drive and pull into pad levels.
// Assumes the controller's pad outputs are registered on ref_clk.
`timescale 1ns/1ps
module gpc_pad_model
    import gpc_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire gpc_pad_t        pad,
    input  wire logic [PINS-1:0] ext_drive,
    input  wire logic [PINS-1:0] ext_level,
    output logic      [PINS-1:0] pad_in
);
    logic [PINS-1:0] float_q = 32'h0;

    // An undriven pad changes every cycle so a stale sample cannot pass by luck.
    always @(posedge ref_clk)
        float_q <= ~float_q;

    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (!pad.oe_n[i])
                pad_in[i] = pad.level[i];
            else if (ext_drive[i])
                pad_in[i] = ext_level[i];
            else if (pad.pull_en[i])
                pad_in[i] = pad.pull_up[i];
            else
                pad_in[i] = float_q[i];
        end
    end
endmodule : gpc_pad_model

// File: verification/gpc_tb_top.sv
// Self-checking bench for the pin controller with the pad model.
// Assumes the one-cycle local and one- or three-cycle peripheral answers of gpc_top.
`timescale 1ns/1ps
module gpc_tb_top;
    import gpc_pkg::*;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [3:0]  b;
        logic [31:0] d;
        logic        e;
        logic [31:0] x;
    } gpc_row_t;
    logic ref_clk, rst, p_dbg, guard, clk_run;
    gpc_req_t l_req, p_req;
    gpc_rsp_t l_rsp, p_rsp;
    gpc_pad_t pad;
    gpc_pf_t pf;
    logic [31:0] pad_in, pf_in, ext_drv, ext_lvl, rd;
    int fail_count, n_compared;
    gpc_row_t rows[15] = '{
        '{1'h1, 12'h000, 4'hf, 32'h0000_00f0, 1'h0, 32'h0},
        '{1'h0, 12'h000, 4'hf, 32'h0, 1'h0, 32'h0000_00f0},
        '{1'h1, 12'h008, 4'h1, 32'h0000_000f, 1'h0, 32'h0},
        '{1'h1, 12'h004, 4'hf, 32'h0000_0011, 1'h0, 32'h0},
        '{1'h1, 12'h00c, 4'h2, 32'h0000_ff01, 1'h0, 32'h0},
        '{1'h0, 12'h008, 4'hf, 32'h0, 1'h0, 32'h0000_ffee},
        '{1'h1, 12'h010, 4'h3, 32'h1234_5678, 1'h0, 32'h0},
        '{1'h1, 12'h018, 4'hc, 32'h8000_0001, 1'h0, 32'h0},
        '{1'h1, 12'h014, 4'hf, 32'h0000_0008, 1'h0, 32'h0},
        '{1'h1, 12'h01c, 4'hf, 32'h0000_00ff, 1'h0, 32'h0},
        '{1'h0, 12'h01c, 4'hf, 32'h0, 1'h0, 32'h8000_568f},
        '{1'h0, 12'h024, 4'hf, 32'h0, 1'h1, 32'h0},
        '{1'h0, 12'h080, 4'hf, 32'h0, 1'h1, 32'h0},
        '{1'h1, 12'h002, 4'hf, 32'hffff_ffff, 1'h1, 32'h0},
        '{1'h0, 12'h000, 4'hf, 32'h0, 1'h0, 32'h0000_ffee}};

    gpc_top dut_u (.REF_CLK(ref_clk), .RST(rst), .L_REQ(l_req), .L_RSP(l_rsp), .P_REQ(p_req),
        .P_DEBUG(p_dbg), .P_RSP(p_rsp), .WRITE_GUARD_ON(guard), .PAD_IN(pad_in), .PAD(pad),
        .PF(pf), .PF_IN(pf_in));
    gpc_pad_model pad_u (.ref_clk(ref_clk), .pad(pad), .ext_drive(ext_drv), .ext_level(ext_lvl),
        .pad_in(pad_in));

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit

    task automatic lcl(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
                       input logic e, output logic [31:0] r);
        @(posedge ref_clk);
        l_req <= '{1'h1, w, a, b, d};
        @(posedge ref_clk);
        l_req.req <= 1'h0;
        #1;
        cmp_bit(l_rsp.ack, 1'h1);
        cmp_bit(l_rsp.err, e);
        r = l_rsp.rdata;
    endtask : lcl

    // The answer latency is fixed by the access kind, so the request is dropped on that edge.
    task automatic per(input logic w, input logic [11:0] a, input logic [31:0] d, input logic g,
                       input int n, input logic e, output logic [31:0] r);
        @(posedge ref_clk);
        p_req <= '{1'h1, w, a, 4'hf, d};
        p_dbg <= g;
        repeat (n - 1)
        begin
            @(posedge ref_clk);
            #1 cmp_bit(p_rsp.ack, 1'h0);
        end
        @(posedge ref_clk);
        p_req.req <= 1'h0;
        #1;
        cmp_bit(p_rsp.ack, 1'h1);
        cmp_bit(p_rsp.err, e);
        r = p_rsp.rdata;
    endtask : per

    task automatic summarize;
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    initial
    begin
        ref_clk = 1'h0;
        forever
        begin
            #20;
            if (clk_run)
                ref_clk = ~ref_clk;
        end
    end

    initial
    begin
        #400000;
        fail_count++;
        summarize();
    end

    initial
    begin
        {l_req, p_req, pf, ext_drv, ext_lvl, p_dbg, guard, fail_count, n_compared} = '0;
        clk_run = 1'h1;
        #1 rst = 1'h1;
        @(posedge ref_clk);
        #1 cmp_word(pad.oe_n, 32'hffff_ffff);
        cmp_word(pad.sense_on | pad.pull_en, 32'h0);
        @(posedge ref_clk);
        rst <= 1'h0;
        foreach (rows[i])
        begin
            lcl(rows[i].w, rows[i].a, rows[i].b, rows[i].d, rows[i].e, rd);
            if (!rows[i].w)
                cmp_word(rd, rows[i].x);
        end
        cmp_word(pad.oe_n, 32'hffff_0011);
        cmp_word(pad.level & 32'h0000_ffee, 32'h0000_568e);
        $display("test local table finished");
        @(posedge ref_clk);
        l_req <= '{1'h1, 1'h1, 12'h008, 4'h4, 32'h0001_0000};
        @(posedge ref_clk);
        l_req <= '{1'h1, 1'h0, 12'h000, 4'hf, 32'h0};
        #1 cmp_bit(l_rsp.ack, 1'h1);
        @(posedge ref_clk);
        l_req.req <= 1'h0;
        #1 cmp_word(l_rsp.rdata, 32'h0001_ffee);
        @(posedge ref_clk);
        l_req <= '{1'h1, 1'h0, 12'h010, 4'hf, 32'h0};
        p_req <= '{1'h1, 1'h0, 12'h000, 4'hf, 32'h0};
        @(posedge ref_clk);
        l_req.req <= 1'h0;
        #1 cmp_bit(p_rsp.ack, 1'h0);
        @(posedge ref_clk);
        p_req.req <= 1'h0;
        #1 cmp_bit(p_rsp.ack, 1'h1);
        cmp_word(p_rsp.rdata, 32'h0001_ffee);
        $display("test back to back finished");
        lcl(1'h1, 12'h000, 4'hf, 32'h0000_0001, 1'h0, rd);
        per(1'h1, 12'h040, 32'h0202_0202, 1'h0, 1, 1'h0, rd);
        per(1'h1, 12'h044, 32'h0004_0300, 1'h0, 1, 1'h0, rd);
        ext_drv <= 32'h0000_004e;
        ext_lvl <= 32'h0000_004a;
        per(1'h0, 12'h020, 32'h0, 1'h0, 3, 1'h0, rd);
        cmp_word(rd & 32'h0000_004f, 32'h0000_000b);
        ext_lvl <= 32'h0000_0048;
        lcl(1'h0, 12'h020, 4'hf, 32'h0, 1'h0, rd);
        cmp_word(rd & 32'h0000_004f, 32'h0000_000b);
        per(1'h1, 12'h024, 32'h0000_0001, 1'h0, 1, 1'h0, rd);
        repeat (3) @(posedge ref_clk);
        lcl(1'h0, 12'h020, 4'hf, 32'h0, 1'h0, rd);
        cmp_word(rd & 32'h0000_004f, 32'h0000_0009);
        cmp_word(pad.sense_on & 32'h0000_006f, 32'h0000_002f);
        cmp_word(pad.pull_en, 32'h0000_0040);
        cmp_word(pad.pull_up & 32'h0000_0040, 32'h0);
        lcl(1'h1, 12'h008, 4'h1, 32'h0000_0040, 1'h0, rd);
        repeat (2) @(posedge ref_clk);
        #1 cmp_word(pad.pull_en, 32'h0);
        $display("test input sampling finished");
        pf <= '{32'h0000_0020, 32'h0000_0020};
        repeat (3) @(posedge ref_clk);
        #1 cmp_bit(pad.oe_n[5], 1'h0);
        cmp_word(pf_in & 32'h0000_0020, 32'h0000_0020);
        per(1'h1, 12'h030, {12'h0, ANALOG_FUNC, 16'h0}, 1'h0, 1, 1'h0, rd);
        repeat (2) @(posedge ref_clk);
        #1 cmp_bit(pad.oe_n[5], 1'h0);
        per(1'h1, 12'h030, {8'h0, ANALOG_FUNC, 20'h0}, 1'h0, 1, 1'h0, rd);
        repeat (2) @(posedge ref_clk);
        #1 cmp_bit(pad.oe_n[5], 1'h1);
        cmp_bit(pad.sense_on[5] | pad.pull_en[5] | pf_in[5], 1'h0);
        $display("test routing finished");
        @(posedge ref_clk);
        guard <= 1'h1;
        lcl(1'h1, 12'h000, 4'hf, 32'h0, 1'h1, rd);
        per(1'h1, 12'h010, 32'h0, 1'h0, 1, 1'h1, rd);
        per(1'h1, 12'h010, 32'h0000_0001, 1'h1, 1, 1'h0, rd);
        per(1'h0, 12'h0a4, 32'h0, 1'h0, 1, 1'h1, rd);
        cmp_word(rd, 32'h0);
        guard <= 1'h0;
        lcl(1'h0, 12'h010, 4'hf, 32'h0, 1'h0, rd);
        cmp_word(rd, 32'h0000_0001);
        lcl(1'h0, 12'h000, 4'hf, 32'h0, 1'h0, rd);
        cmp_word(rd, 32'h0000_0041);
        $display("test write guard finished");
        @(negedge ref_clk);
        clk_run = 1'h0;
        rst = 1'h1;
        #100 cmp_word(pad.oe_n, 32'hffff_ffff);
        cmp_word(pad.sense_on | pad.pull_en | pf_in, 32'h0);
        clk_run = 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        lcl(1'h0, 12'h000, 4'hf, 32'h0, 1'h0, rd);
        cmp_word(rd, 32'h0);
        $display("test clockless reset finished");
        summarize();
    end
endmodule : gpc_tb_top
